//--- core/smc_mode_regs.sv
// Mode, self-test interval and auxiliary pin configuration registers.
`timescale 1ns/1ns
module smc_mode_regs #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] ECO_CYC = CNT_W'(smc_pkg::ECO_PERIOD_CYC),
    parameter logic [CNT_W-1:0] NORMAL_CYC = CNT_W'(smc_pkg::NORMAL_PERIOD_CYC)
) (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port.
    input wire smc_pkg::smc_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Function requests from the PWM encoder and supply control.
    input wire logic pwm_active,
    input wire logic supply_active,
    // Pins and events.
    output logic pwm_pin,
    output logic aux_port_pin,
    output logic aux_port_pin_oe,
    output logic sample_tick,
    output logic selftest_tick
);
    // Stored configuration bytes, reserved bits already masked to zero.
    logic [7:0] operating_mode_config; // Mode and PWM polarity.
    logic [7:0] selftest_interval; // Sampling periods per self-test.
    logic [7:0] aux_pin_function; // Auxiliary pin function code.
    // Field views of the stored bytes.
    logic pwm_polarity_sel; // High: the PWM pin asserts high.
    logic [2:0] aux_code; // Function code of the auxiliary pin.
    // Next pin levels, registered below so that the pins never glitch.
    logic next_pwm_pin; // Next PWM pin level.
    logic next_aux_pin; // Next auxiliary pin level.
    logic next_aux_oe; // Next auxiliary output enable.

    // Decodes a register address for both the write and the read path, so that the
    // two can never disagree about the map; index zero means that no register answers.
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        logic [1:0] idx;
        case (addr)
            smc_pkg::ADDR_MODE_CFG:
                idx = 2'h1;
            smc_pkg::ADDR_ST_INTERVAL:
                idx = 2'h2;
            smc_pkg::ADDR_AUX_FUNC:
                idx = 2'h3;
            default:
                idx = 2'h0;
        endcase
        return idx;
    endfunction : reg_index

    // Polarity bit and auxiliary code sliced out of the stored bytes.
    assign pwm_polarity_sel = operating_mode_config[smc_pkg::BIT_PWM_POL];
    assign aux_code = aux_pin_function[2:0];

    // Register writes; reserved bits are masked on the way in.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            operating_mode_config <= smc_pkg::RST_MODE_CFG;
            selftest_interval <= smc_pkg::RST_ST_INTERVAL;
            aux_pin_function <= smc_pkg::RST_AUX_FUNC;
        end
        else if (clk_en && req.wr)
        begin
            case (reg_index(req.addr))
                2'h1:
                    operating_mode_config <= req.wdata & smc_pkg::MASK_MODE_CFG;
                // The interval uses all eight bits, so nothing is masked here.
                2'h2:
                    selftest_interval <= req.wdata;
                2'h3:
                    aux_pin_function <= req.wdata & smc_pkg::MASK_AUX_FUNC;
                // A write to an address that holds no register is dropped.
                default:
                    ;
            endcase
        end
    end

    // Read data is registered one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else if (clk_en)
        begin
            // The valid flag follows the strobe, so it is a one-cycle pulse per read.
            rvalid <= req.rd;
            // Reads have no side effect; a write in the same cycle shows at the next read.
            if (req.rd)
            begin
                case (reg_index(req.addr))
                    2'h1:
                        rdata <= operating_mode_config;
                    2'h2:
                        rdata <= selftest_interval;
                    2'h3:
                        rdata <= aux_pin_function;
                    default:
                        rdata <= 8'h00;
                endcase
            end
        end
    end

    // Pin level decode.
    always_comb
    begin
        next_pwm_pin = pwm_polarity_sel ? pwm_active : ~pwm_active;
        case (aux_code)
            smc_pkg::AUX_SUPPLY_ACT_LOW:
            begin
                next_aux_pin = ~supply_active;
                next_aux_oe = 1'b1;
            end
            smc_pkg::AUX_SUPPLY_ACT_HIGH:
            begin
                next_aux_pin = supply_active;
                next_aux_oe = 1'b1;
            end
            // A disabled pin is released and held low, so it never shows a stale level.
            // pin disabled
            default:
            begin
                next_aux_pin = 1'b0;
                next_aux_oe = 1'b0;
            end
        endcase
    end

    // Pins are registered so they come straight from flip-flops.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            // Idle level of an active-low PWM after reset.
            pwm_pin <= 1'b1;
            aux_port_pin <= 1'b0;
            aux_port_pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            // A frozen block keeps its pin levels along with all other state.
            pwm_pin <= next_pwm_pin;
            aux_port_pin <= next_aux_pin;
            aux_port_pin_oe <= next_aux_oe;
        end
    end

    // Sampling and self-test scheduling.
    // The timer sees the mode bit directly, so a mode change takes hold at once
    // rather than at the end of the running period.
    smc_period_timer #(
        .CNT_W(CNT_W),
        .ECO_CYC(ECO_CYC),
        .NORMAL_CYC(NORMAL_CYC)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .normal_mode(operating_mode_config[smc_pkg::BIT_MODE]),
        .interval(selftest_interval),
        .sample_tick(sample_tick),
        .selftest_tick(selftest_tick)
    );

    // Rule checks on the pins, registers and read answers of this block.
    a_pwm_polarity: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en |=> pwm_pin == ($past(pwm_polarity_sel) ? $past(pwm_active) : !$past(pwm_active)))
        else $error("PWM level does not follow polarity.");
    a_eco_no_tick: assert property (@(posedge ref_clk) disable iff (rst)
        (sample_tick && !operating_mode_config[0] && clk_en) |=> !sample_tick)
        else $error("Sample tick repeated too soon.");
    a_zero_no_test: assert property (@(posedge ref_clk) disable iff (rst)
        (selftest_interval == 8'h00 && $past(selftest_interval) == 8'h00
         && $past(selftest_interval, 2) == 8'h00) |-> !selftest_tick)
        else $error("Self-test ran with interval zero.");
    a_test_on_tick: assert property (@(posedge ref_clk) disable iff (rst)
        selftest_tick |-> $past(sample_tick))
        else $error("Self-test not aligned to sample period.");
    a_aux_low: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && aux_code == 3'h4) |=> aux_port_pin_oe && aux_port_pin == !$past(supply_active))
        else $error("Active-low supply enable wrong.");
    a_aux_high: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && aux_code == 3'h5) |=> aux_port_pin_oe && aux_port_pin == $past(supply_active))
        else $error("Active-high supply enable wrong.");
    a_aux_off: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && aux_code != 3'h4 && aux_code != 3'h5) |=> !aux_port_pin_oe)
        else $error("Aux pin driven while disabled.");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
        operating_mode_config[7:2] == 6'h00 && aux_pin_function[7:3] == 5'h00)
        else $error("Reserved bits not zero.");
    a_reset_clear: assert property (@(posedge ref_clk)
        $fell(rst) |-> operating_mode_config == 8'h00 && selftest_interval == 8'h01)
        else $error("Reset values wrong.");
    a_mode_read_masked: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.rd && req.addr == smc_pkg::ADDR_MODE_CFG)
        |=> rvalid && rdata[7:2] == 6'h00)
        else $error("Reserved mode bits read as one.");
    a_aux_read_masked: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.rd && req.addr == smc_pkg::ADDR_AUX_FUNC)
        |=> rvalid && rdata[7:3] == 5'h00)
        else $error("Reserved aux bits read as one.");
endmodule : smc_mode_regs

//--- pkg/smc_pkg.sv
// Shared constants and types of the sensor mode configuration block.
package smc_pkg;
    // Register byte addresses on the internal register port.
    localparam logic [7:0] ADDR_MODE_CFG = 8'h50;
    localparam logic [7:0] ADDR_ST_INTERVAL = 8'h51;
    localparam logic [7:0] ADDR_AUX_FUNC = 8'h52;
    // Reset values.
    localparam logic [7:0] RST_MODE_CFG = 8'h00;
    localparam logic [7:0] RST_ST_INTERVAL = 8'h01;
    localparam logic [7:0] RST_AUX_FUNC = 8'h00;
    // Writable bit masks; reserved bits read as zero.
    localparam logic [7:0] MASK_MODE_CFG = 8'h03;
    localparam logic [7:0] MASK_AUX_FUNC = 8'h07;
    // Field positions.
    localparam int BIT_MODE = 0;
    localparam int BIT_PWM_POL = 1;
    // Auxiliary pin function codes.
    localparam logic [2:0] AUX_SUPPLY_ACT_LOW = 3'h4;
    localparam logic [2:0] AUX_SUPPLY_ACT_HIGH = 3'h5;
    // Sampling periods in ms and in clock cycles at 25 MHz.
    localparam longint CLK_HZ = 25000000;
    localparam longint ECO_PERIOD_MS = 500;
    localparam longint NORMAL_PERIOD_MS = 50;
    localparam longint ECO_PERIOD_CYC = ECO_PERIOD_MS * CLK_HZ / 1000;
    localparam longint NORMAL_PERIOD_CYC = NORMAL_PERIOD_MS * CLK_HZ / 1000;
    // Register port request carried as one bundle.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smc_req_t;
endpackage : smc_pkg

//--- core/smc_period_timer.sv
// Sampling period tick generator and self-test scheduler.
`timescale 1ns/1ns
module smc_period_timer #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] ECO_CYC = CNT_W'(smc_pkg::ECO_PERIOD_CYC),
    parameter logic [CNT_W-1:0] NORMAL_CYC = CNT_W'(smc_pkg::NORMAL_PERIOD_CYC)
) (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Configuration.
    input wire logic normal_mode,
    input wire logic [7:0] interval,
    // Events.
    output logic sample_tick,
    output logic selftest_tick
);
    // Cycle counter within one sampling period.
    logic [CNT_W-1:0] cyc_cnt;
    // Sampling periods counted since the last self-test.
    logic [7:0] per_cnt;
    logic [CNT_W-1:0] period_len;

    // Period length follows the mode bit at once.
    // mode picks period
    assign period_len = normal_mode ? NORMAL_CYC : ECO_CYC;

    // Free running period counter; a mode change sets the new period length at once.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cyc_cnt <= '0;
            sample_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cyc_cnt >= period_len - CNT_W'(1))
            begin
                cyc_cnt <= '0;
                sample_tick <= 1'b1;
            end
            else
            begin
                cyc_cnt <= cyc_cnt + CNT_W'(1);
                sample_tick <= 1'b0;
            end
        end
    end

    // Self-test every N sampling periods, none when N is zero.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            per_cnt <= 8'h00;
            selftest_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            selftest_tick <= 1'b0;
            if (interval == 8'h00)
            begin
                per_cnt <= 8'h00;
            end
            else if (sample_tick)
            begin
                if (per_cnt + 8'h01 >= interval)
                begin
                    per_cnt <= 8'h00;
                    selftest_tick <= 1'b1;
                end
                else
                begin
                    per_cnt <= per_cnt + 8'h01;
                end
            end
        end
    end
endmodule : smc_period_timer

//--- bench/smc_mode_regs_tb.sv
// Self-checking testbench of the sensor mode configuration registers.
`timescale 1ns/1ns
module smc_mode_regs_tb;
    // Clock, reset, enable and request inputs.
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    smc_pkg::smc_req_t req = '0;
    logic pwm_active = 1'b0;
    logic supply_active = 1'b0;
    // Design outputs.
    logic [7:0] rdata;
    logic rvalid, pwm_pin, aux_port_pin, aux_port_pin_oe, sample_tick, selftest_tick;
    // Register model, counters and the random seed.
    int mdl [3];
    int n_fail = 0;
    int checked = 0;
    int seed = 49739;
    int cycles = 0;
    int gap, k, code, n;
    // Short sampling periods keep the run brief; expectations use 20 and 5.
    smc_mode_regs #(.CNT_W(24), .ECO_CYC(24'h14), .NORMAL_CYC(24'h05)) i_smc_mode_regs (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req), .rdata(rdata),
        .rvalid(rvalid), .pwm_active(pwm_active), .supply_active(supply_active),
        .pwm_pin(pwm_pin), .aux_port_pin(aux_port_pin), .aux_port_pin_oe(aux_port_pin_oe),
        .sample_tick(sample_tick), .selftest_tick(selftest_tick));
    // Free-running clock of 40 ns.
    initial forever #20 ref_clk = ~ref_clk;
    // A hang is cut short well above the expected run length.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end
    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // Compares a byte or a pin level.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    // Compares a count of cycles or events worked out by the bench.
    task automatic chk_num(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_num
    // Writes one register; the model keeps only the writable bits.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge ref_clk);
        req.wr = 1'b0;
        if (clk_en && a == smc_pkg::ADDR_MODE_CFG)
            mdl[0] = d & smc_pkg::MASK_MODE_CFG;
        if (clk_en && a == smc_pkg::ADDR_ST_INTERVAL)
            mdl[1] = d;
        if (clk_en && a == smc_pkg::ADDR_AUX_FUNC)
            mdl[2] = d & smc_pkg::MASK_AUX_FUNC;
        // One idle cycle, so the next call never raises the strobe in this time step.
        @(negedge ref_clk);
    endtask : wr
    // Reads one register and compares it with the model; unmapped reads give zero.
    task automatic rd(input logic [7:0] a);
        int exp;
        exp = (a >= 8'h50 && a <= 8'h52) ? mdl[int'(a) - 80] : 0;
        req.rd = 1'b1;
        req.addr = a;
        @(negedge ref_clk);
        req.rd = 1'b0;
        k = 0;
        while (rvalid !== 1'b1 && k < 3)
        begin
            @(negedge ref_clk);
            k++;
        end
        chk8(8'(rvalid), 8'h01);
        chk8(rdata, 8'(exp));
        // One idle cycle, so the next call never raises the strobe in this time step.
        @(negedge ref_clk);
    endtask : rd
    // Cycles between two sampling ticks.
    task automatic tick_gap(output int g);
        k = 0;
        while (sample_tick !== 1'b1 && k < 100)
        begin
            @(negedge ref_clk);
            k++;
        end
        @(negedge ref_clk);
        g = 1;
        while (sample_tick !== 1'b1 && g < 100)
        begin
            @(negedge ref_clk);
            g++;
        end
    endtask : tick_gap
    // Sampling ticks between two self-test ticks; the first wait skips a stale count.
    task automatic st_gap(output int g);
        k = 0;
        while (selftest_tick !== 1'b1 && k < 3000)
        begin
            @(negedge ref_clk);
            k++;
        end
        g = 0;
        k = 0;
        @(negedge ref_clk);
        while (selftest_tick !== 1'b1 && k < 3000)
        begin
            g = g + int'(sample_tick === 1'b1);
            @(negedge ref_clk);
            k++;
        end
    endtask : st_gap
    // Main sequence, driven at the falling edge.
    initial
    begin
        mdl[0] = smc_pkg::RST_MODE_CFG;
        mdl[1] = smc_pkg::RST_ST_INTERVAL;
        mdl[2] = smc_pkg::RST_AUX_FUNC;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        rd(8'h50);
        rd(8'h51);
        rd(8'h52);
        rd(8'h53);
        wr(8'h50, 8'hff);
        rd(8'h50);
        wr(8'h52, 8'hff);
        rd(8'h52);
        wr(8'h51, 8'($random(seed)));
        rd(8'h51);
        // A frozen block must not take a write.
        clk_en = 1'b0;
        wr(8'h51, 8'haa);
        clk_en = 1'b1;
        rd(8'h51);
        // Every polarity with every auxiliary code, under random request levels.
        for (code = 0; code < 16; code++)
        begin
            wr(8'h50, {6'h0, code[3], 1'b1});
            wr(8'h52, {5'h0, code[2:0]});
            repeat (4)
            begin
                pwm_active = 1'($random(seed));
                supply_active = 1'($random(seed));
                repeat (2) @(negedge ref_clk);
                chk8(8'(pwm_pin), 8'(code[3] ? pwm_active : !pwm_active));
                chk8(8'(aux_port_pin_oe), 8'(code[2:1] == 2'b10));
                chk8(8'(aux_port_pin), 8'(code[2:1] == 2'b10 && (code[0] ~^ supply_active)));
            end
        end
        // Sampling period in both modes, a tick skipped after each change.
        wr(8'h50, 8'h01);
        tick_gap(gap);
        tick_gap(gap);
        chk_num(gap, 5);
        wr(8'h50, 8'h00);
        tick_gap(gap);
        tick_gap(gap);
        chk_num(gap, 20);
        // Self-test spacing at both ends of the range and one random value.
        wr(8'h50, 8'h01);
        for (code = 0; code < 3; code++)
        begin
            n = (code == 0) ? 1 : (code == 1) ? 255 : 2 + ($unsigned($random(seed)) % 253);
            wr(8'h51, 8'(n));
            st_gap(gap);
            st_gap(gap);
            chk_num(gap, n);
        end
        wr(8'h51, 8'h00);
        repeat (2) @(negedge ref_clk);
        n = 0;
        repeat (300)
        begin
            @(negedge ref_clk);
            n = n + int'(selftest_tick !== 1'b0);
        end
        chk_num(n, 0);
        // A reset in mid-run must bring every register back to its reset value.
        wr(8'h50, 8'h03);
        wr(8'h52, 8'h05);
        rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        mdl[0] = smc_pkg::RST_MODE_CFG;
        mdl[1] = smc_pkg::RST_ST_INTERVAL;
        mdl[2] = smc_pkg::RST_AUX_FUNC;
        rd(8'h50);
        rd(8'h51);
        rd(8'h52);
        chk8(8'(aux_port_pin_oe), 8'h00);
        stop_test();
    end
endmodule : smc_mode_regs_tb
